// ==== core/sgcd_pkg.sv ====
// shared types and constants for the sgram command decoder
package sgcd_pkg;
   localparam int CA_W = 11;
   localparam int CA9 = 9;
   localparam int CA8 = 8;
   localparam int CA7 = 7;
   localparam int CA6 = 6;
   localparam int CA4 = 4;
   localparam int CA3 = 3;
   localparam int NIB = 4;
   localparam int BYTE = 8;
   localparam logic [3:0] MRA_VEND_A = 4'hd;
   localparam logic [3:0] MRA_VEND_B = 4'he;
   localparam logic [3:0] MRA_CTRL = 4'hf;
   localparam int TRAINING_AND_WRITE_BLOCK_CTRL_BLK_A = 0;
   localparam int TRAINING_AND_WRITE_BLOCK_CTRL_BLK_B = 1;
   localparam int TRAINING_AND_WRITE_BLOCK_CTRL_SEL_LO = 2;
   localparam logic [1:0] SEL_RST = 2'h0;
   localparam logic CKE_N_RST = 1'h1;

   typedef enum logic [3:0] {
      K_NOP, K_MRS, K_ACT, K_RD, K_WR, K_LDFF, K_RDTR, K_WRTR, K_PRE, K_REF, K_PDE
   } sgcd_kind_t;

   typedef enum logic [1:0] {M_NONE, M_DOUBLE, M_SINGLE} sgcd_mask_t;

   typedef struct packed {
      sgcd_kind_t kind;
      sgcd_mask_t mask_kind;
      logic [3:0] bank;
      logic [13:0] row;
      logic [6:0] col;
      logic auto_pre;     // also all-banks for pre/ref
      logic chan_en;
      logic [15:0] mask0;
      logic [15:0] mask1;
      logic [9:0] ldff_data; // burst position sits in bank
   } sgcd_cmd_t;

   typedef struct packed {
      logic [3:0] addr;
      logic [11:0] op;
   } sgcd_mrs_t;
endpackage : sgcd_pkg

// ==== core/sgcd_decoder.sv ====
// per-channel command/address decoder with the training/block register
`timescale 1ns/100ps
module sgcd_decoder (
   input wire logic clk_sys,                   // 100 MHz command clock
   input wire logic rstn,                      // async reset, active low
   input wire logic chan_is_b,                 // high when serving channel b
   input wire logic cke_n,                     // clock enable, active low
   input wire logic [10:0] ca_rise,            // ca sampled at rising ck
   input wire logic [10:0] ca_fall,            // ca sampled at falling ck
   input wire logic ca_inversion_pin_rise,     // inversion pin, rising edge
   input wire logic ca_inversion_pin_fall,     // inversion pin, falling edge
   input wire logic ca_inv_en,                 // ca bus inversion enabled
   output sgcd_pkg::sgcd_cmd_t cmd,            // decoded command
   output logic cmd_valid,                     // one-cycle strobe for cmd
   output logic array_access,                  // read/write reaches array
   output sgcd_pkg::sgcd_mrs_t mrs,            // last mode write, accepted or blocked
   output logic mrs_valid,                     // one-cycle strobe for mrs
   output logic mrs_vendor,                    // mrs hit register d or e
   output logic chan_a_mode_write_block,       // stored block bit a
   output logic chan_b_mode_write_block,       // stored block bit b
   output logic [1:0] ca_training_select       // training target
);
   typedef enum logic [1:0] {S_IDLE, S_MASK_A, S_MASK_B} sgcd_state_t;

   sgcd_state_t state;
   logic cke_n_prev;
   logic [10:0] lr;
   logic [10:0] lf;
   logic lowlow;
   logic pde;
   sgcd_pkg::sgcd_cmd_t dec;
   sgcd_pkg::sgcd_cmd_t hold;
   logic [15:0] mask_in;
   logic mrs_hit;
   logic [3:0] mra;
   logic blocked;

   // logical levels; ca10 is never looked at below
   assign lr = (ca_inv_en && !ca_inversion_pin_rise) ? ~ca_rise : ca_rise;
   assign lf = (ca_inv_en && !ca_inversion_pin_fall) ? ~ca_fall : ca_fall;
   assign lowlow = !cke_n_prev && !cke_n;
   assign pde = !cke_n_prev && cke_n && lr[sgcd_pkg::CA9] && lr[sgcd_pkg::CA8];
   assign mask_in = {lf[sgcd_pkg::BYTE-1:0], lr[sgcd_pkg::BYTE-1:0]};
   assign mra = lr[sgcd_pkg::CA7:sgcd_pkg::CA4];
   assign mrs_hit = lowlow && (state == S_IDLE) && (dec.kind == sgcd_pkg::K_MRS);
   // register f itself is exempt so blocking can always be undone
   assign blocked = (mra != sgcd_pkg::MRA_CTRL) && (chan_is_b ?
      chan_b_mode_write_block : chan_a_mode_write_block);

   // previous cke for the two-cycle qualifiers
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         cke_n_prev <= sgcd_pkg::CKE_N_RST;
      end else begin
         cke_n_prev <= cke_n;
      end
   end

   // command table; fields not used by a kind are don't-care
   always_comb begin
      dec = '0;
      dec.kind = sgcd_pkg::K_NOP;
      dec.bank = lr[sgcd_pkg::CA7:sgcd_pkg::CA4];
      dec.col = {lf[2:0], lr[3:0]};
      dec.auto_pre = lf[sgcd_pkg::CA4];
      dec.chan_en = lf[sgcd_pkg::CA3];
      dec.ldff_data = {lf[5:4], lf[3:0], lr[3:0]};
      if (!lr[sgcd_pkg::CA9]) begin
         dec.kind = sgcd_pkg::K_ACT;
         dec.row = {lf[9:0], lr[3:0]};
      end else if (lr[sgcd_pkg::CA8]) begin
         unique case ({lf[sgcd_pkg::CA9], lf[sgcd_pkg::CA8]})
            2'h1: begin
               unique case ({lf[sgcd_pkg::CA7], lf[sgcd_pkg::CA6]})
                  2'h0: dec.kind = sgcd_pkg::K_RD;
                  2'h2: dec.kind = sgcd_pkg::K_LDFF;
                  2'h3: dec.kind = sgcd_pkg::K_RDTR;
                  2'h1: dec.kind = sgcd_pkg::K_NOP;
               endcase
            end
            2'h0: begin
               dec.kind = sgcd_pkg::K_WR;
               unique case ({lf[sgcd_pkg::CA7], lf[sgcd_pkg::CA6]})
                  2'h0: dec.mask_kind = sgcd_pkg::M_NONE;
                  2'h2: dec.mask_kind = sgcd_pkg::M_DOUBLE;
                  2'h1: dec.mask_kind = sgcd_pkg::M_SINGLE;
                  2'h3: dec.kind = sgcd_pkg::K_WRTR;
               endcase
            end
            2'h2, 2'h3: dec.kind = sgcd_pkg::K_NOP;
         endcase
      end else begin
         unique case ({lf[sgcd_pkg::CA9], lf[sgcd_pkg::CA8]})
            2'h2: dec.kind = sgcd_pkg::K_MRS;
            2'h0: dec.kind = sgcd_pkg::K_PRE;
            2'h1: dec.kind = sgcd_pkg::K_REF;
            2'h3: dec.kind = sgcd_pkg::K_NOP;
         endcase
      end
   end

   // masked writes collect their mask cycles before issuing
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         state <= S_IDLE;
      end else begin
         unique case (state)
            S_IDLE: begin
               if (lowlow && dec.kind == sgcd_pkg::K_WR && dec.mask_kind != sgcd_pkg::M_NONE)
                  state <= S_MASK_A;
            end
            S_MASK_A: begin
               state <= (lowlow && hold.mask_kind == sgcd_pkg::M_SINGLE) ? S_MASK_B : S_IDLE;
            end
            S_MASK_B: state <= S_IDLE;
            default: state <= S_IDLE;
         endcase
      end
   end

   // held bank/column of a pending masked write
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         hold <= '0;
      end else if (state == S_IDLE) begin
         hold <= dec;
      end else if (state == S_MASK_A) begin
         hold.mask0 <= mask_in;
      end
   end

   // command strobe; a broken mask sequence is dropped, not half-issued
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         cmd <= '0;
         cmd_valid <= 1'h0;
         array_access <= 1'h0;
      end else begin
         cmd_valid <= 1'h0;
         array_access <= 1'h0;
         unique case (state)
            S_IDLE: begin
               if (pde) begin
                  cmd <= '0;
                  cmd.kind <= sgcd_pkg::K_PDE;
                  cmd_valid <= 1'h1;
               end else if (lowlow && dec.kind != sgcd_pkg::K_NOP
                            && dec.kind != sgcd_pkg::K_MRS
                            && !(dec.kind == sgcd_pkg::K_WR && dec.mask_kind != sgcd_pkg::M_NONE)) begin
                  cmd <= dec;
                  cmd_valid <= 1'h1;
                  array_access <= (dec.kind == sgcd_pkg::K_RD || dec.kind == sgcd_pkg::K_WR)
                                  && dec.chan_en;
               end
            end
            S_MASK_A: begin
               if (lowlow && hold.mask_kind == sgcd_pkg::M_DOUBLE) begin
                  cmd <= hold;
                  cmd.mask0 <= mask_in;
                  cmd_valid <= 1'h1;
                  array_access <= hold.chan_en;
               end
            end
            S_MASK_B: begin
               if (lowlow) begin
                  cmd <= hold;
                  cmd.mask1 <= mask_in;
                  cmd_valid <= 1'h1;
                  array_access <= hold.chan_en;
               end
            end
            default: cmd_valid <= 1'h0;
         endcase
      end
   end

   // register f: only rising-edge bits count
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         chan_a_mode_write_block <= 1'h0;
         chan_b_mode_write_block <= 1'h0;
         ca_training_select <= sgcd_pkg::SEL_RST;
      end else if (mrs_hit && mra == sgcd_pkg::MRA_CTRL) begin
         chan_a_mode_write_block <= lr[sgcd_pkg::TRAINING_AND_WRITE_BLOCK_CTRL_BLK_A];
         chan_b_mode_write_block <= lr[sgcd_pkg::TRAINING_AND_WRITE_BLOCK_CTRL_BLK_B];
         ca_training_select <= lr[sgcd_pkg::TRAINING_AND_WRITE_BLOCK_CTRL_SEL_LO+1:sgcd_pkg::TRAINING_AND_WRITE_BLOCK_CTRL_SEL_LO];
      end
   end

   // accepted mode writes go out for the registers that live elsewhere
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         mrs <= '0;
         mrs_valid <= 1'h0;
         mrs_vendor <= 1'h0;
      end else begin
         mrs_valid <= mrs_hit && !blocked;
         mrs_vendor <= mrs_hit && !blocked &&
                       (mra == sgcd_pkg::MRA_VEND_A || mra == sgcd_pkg::MRA_VEND_B);
         if (mrs_hit) begin
            mrs.addr <= mra;
            mrs.op <= {lf[sgcd_pkg::BYTE-1:0], lr[sgcd_pkg::NIB-1:0]};
         end
      end
   end

   // checks
   property p_training_and_write_block_ctrl_rise;
      @(posedge clk_sys) disable iff (!rstn)
      (mrs_hit && mra == sgcd_pkg::MRA_CTRL) |=>
         chan_a_mode_write_block == $past(lr[0]) && chan_b_mode_write_block == $past(lr[1]);
   endproperty
   a_training_and_write_block_ctrl_rise: assert property (p_training_and_write_block_ctrl_rise) else $error("reg f bits wrong");

   property p_block_a;
      @(posedge clk_sys) disable iff (!rstn)
      (mrs_hit && !chan_is_b && chan_a_mode_write_block && mra != sgcd_pkg::MRA_CTRL)
         |=> !mrs_valid;
   endproperty
   a_block_a: assert property (p_block_a) else $error("chan a mrs not blocked");

   property p_block_b;
      @(posedge clk_sys) disable iff (!rstn)
      (mrs_hit && chan_is_b && !chan_b_mode_write_block) |=> mrs_valid;
   endproperty
   a_block_b: assert property (p_block_b) else $error("chan b mrs lost");

   property p_block_b_set;
      @(posedge clk_sys) disable iff (!rstn)
      (mrs_hit && chan_is_b && chan_b_mode_write_block && mra != sgcd_pkg::MRA_CTRL)
         |=> !mrs_valid;
   endproperty
   a_block_b_set: assert property (p_block_b_set) else $error("chan b mrs not blocked");

   // register f must stay reachable, or a set block bit could never be undone
   property p_ctrl_open;
      @(posedge clk_sys) disable iff (!rstn)
      (mrs_hit && mra == sgcd_pkg::MRA_CTRL) |=> mrs_valid;
   endproperty
   a_ctrl_open: assert property (p_ctrl_open) else $error("reg f write was blocked");

   property p_train_sel;
      @(posedge clk_sys) disable iff (!rstn)
      (mrs_hit && mra == sgcd_pkg::MRA_CTRL) |=> ca_training_select == $past(lr[3:2]);
   endproperty
   a_train_sel: assert property (p_train_sel) else $error("training select wrong");

   property p_vendor;
      @(posedge clk_sys) disable iff (!rstn)
      (mrs_hit && !blocked && mra == sgcd_pkg::MRA_VEND_B) |=> mrs_valid && mrs_vendor;
   endproperty
   a_vendor: assert property (p_vendor) else $error("vendor mrs dropped");

   property p_nop;
      @(posedge clk_sys) disable iff (!rstn)
      (lowlow && state == S_IDLE && dec.kind == sgcd_pkg::K_NOP) |=> !cmd_valid && !mrs_valid;
   endproperty
   a_nop: assert property (p_nop) else $error("nop issued a command");

   property p_act;
      @(posedge clk_sys) disable iff (!rstn)
      (lowlow && state == S_IDLE && !lr[sgcd_pkg::CA9]) |=>
         cmd_valid && cmd.kind == sgcd_pkg::K_ACT && cmd.row == {$past(lf[9:0]), $past(lr[3:0])};
   endproperty
   a_act: assert property (p_act) else $error("activate decode wrong");

   property p_wdm;
      @(posedge clk_sys) disable iff (!rstn)
      (lowlow && state == S_IDLE && dec.kind == sgcd_pkg::K_WR
       && dec.mask_kind == sgcd_pkg::M_DOUBLE) ##1 lowlow |=> cmd_valid && cmd.mask0 == $past(mask_in);
   endproperty
   a_wdm: assert property (p_wdm) else $error("double mask write wrong");

   property p_wsm;
      @(posedge clk_sys) disable iff (!rstn)
      (state == S_MASK_A && lowlow && hold.mask_kind == sgcd_pkg::M_SINGLE)
         |=> !cmd_valid ##1 (cmd_valid == $past(lowlow)); // qualifier of the byte 1 cycle
   endproperty
   a_wsm: assert property (p_wsm) else $error("single mask write timing");

   property p_ce;
      @(posedge clk_sys) disable iff (!rstn)
      (cmd_valid && !cmd.chan_en) |-> !array_access;
   endproperty
   a_ce: assert property (p_ce) else $error("access with ce low");

   property p_pde;
      @(posedge clk_sys) disable iff (!rstn)
      (state == S_IDLE && pde) |=> cmd_valid && cmd.kind == sgcd_pkg::K_PDE;
   endproperty
   a_pde: assert property (p_pde) else $error("power-down entry missed");
endmodule : sgcd_decoder

// ==== tb/sgcd_ctrl_model.sv ====
// controller-side model that drives the command/address bus of one channel
`timescale 1ns/100ps
module sgcd_ctrl_model (
   input wire logic clk_sys, // command clock
   input wire logic ca_inv_en, // bus inversion enabled in the device
   output logic cke_n, // clock enable, active low
   output logic [10:0] ca_rise, // physical ca for the rising edge
   output logic [10:0] ca_fall, // physical ca for the falling edge
   output logic pin_rise, // inversion pin for the rising edge
   output logic pin_fall // inversion pin for the falling edge
);
   // idle bus carries the plain nop on both edges, never the training-only forms
   initial begin
      cke_n = 1'h0;
      ca_rise = 11'h300;
      ca_fall = 11'h300;
      pin_rise = 1'h1;
      pin_fall = 1'h1;
   end

   // one command cycle as a rise/fall pair; edges inverted at random while ca_inv_en is set, so both polarities occur
   task cyc(input logic [10:0] r, input logic [10:0] f, input logic ck);
      logic inv_r;
      logic inv_f;
      @(posedge clk_sys);
      inv_r = ca_inv_en && ($urandom_range(1) != 0);
      inv_f = ca_inv_en && ($urandom_range(1) != 0);
      cke_n <= ck;
      ca_rise <= inv_r ? ~r : r;
      ca_fall <= inv_f ? ~f : f;
      pin_rise <= ~inv_r;
      pin_fall <= ~inv_f;
   endtask : cyc
endmodule : sgcd_ctrl_model

// ==== tb/sgram_command_decoder_test.sv ====
// self-checking bench for the sgram command decoder
`timescale 1ns/100ps
module sgram_command_decoder_test;
   logic clk_sys, rstn, chan_is_b, ca_inv_en, cke_n, pin_r, pin_f, cmd_valid, array_access;
   logic mrs_valid, mrs_vendor, blk_a_o, blk_b_o, blk_a, blk_b;
   logic [1:0] sel_o, sel;
   logic [10:0] ca_r, ca_f, r, f;
   logic [15:0] m0, m1;
   sgcd_pkg::sgcd_cmd_t cmd;
   sgcd_pkg::sgcd_mrs_t mrs;
   int num_errors, check_count, k;
   // per command: fixed bits and values of each edge, ca10 always left random
   logic [10:0] mr_t [11] = '{11'h300, 11'h200, 11'h300, 11'h300, 11'h300, 11'h300,
      11'h300, 11'h300, 11'h300, 11'h300, 11'h300};
   logic [10:0] vr_t [11] = '{11'h300, 11'h000, 11'h300, 11'h300, 11'h300, 11'h300,
      11'h300, 11'h200, 11'h200, 11'h300, 11'h300};
   logic [10:0] mf_t [11] = '{11'h300, 11'h000, 11'h3c0, 11'h3c0, 11'h3c0, 11'h3c0,
      11'h3c0, 11'h300, 11'h300, 11'h3c0, 11'h3c0};
   logic [10:0] vf_t [11] = '{11'h300, 11'h000, 11'h100, 11'h000, 11'h180, 11'h1c0,
      11'h0c0, 11'h000, 11'h100, 11'h080, 11'h040};
   sgcd_pkg::sgcd_kind_t kd_t [11] = '{sgcd_pkg::K_NOP, sgcd_pkg::K_ACT, sgcd_pkg::K_RD,
      sgcd_pkg::K_WR, sgcd_pkg::K_LDFF, sgcd_pkg::K_RDTR, sgcd_pkg::K_WRTR, sgcd_pkg::K_PRE,
      sgcd_pkg::K_REF, sgcd_pkg::K_WR, sgcd_pkg::K_WR};

   sgcd_ctrl_model u_ctrl (.clk_sys(clk_sys), .ca_inv_en(ca_inv_en), .cke_n(cke_n),
      .ca_rise(ca_r), .ca_fall(ca_f), .pin_rise(pin_r), .pin_fall(pin_f));

   sgcd_decoder u_dut (.clk_sys(clk_sys), .rstn(rstn), .chan_is_b(chan_is_b), .cke_n(cke_n),
      .ca_rise(ca_r), .ca_fall(ca_f), .ca_inversion_pin_rise(pin_r),
      .ca_inversion_pin_fall(pin_f), .ca_inv_en(ca_inv_en), .cmd(cmd), .cmd_valid(cmd_valid),
      .array_access(array_access), .mrs(mrs), .mrs_valid(mrs_valid), .mrs_vendor(mrs_vendor),
      .chan_a_mode_write_block(blk_a_o), .chan_b_mode_write_block(blk_b_o),
      .ca_training_select(sel_o));

   // expected acceptance of a mode write on the channel being served
   function automatic logic mrs_ok(input logic [3:0] a);
      return a == sgcd_pkg::MRA_CTRL || !(chan_is_b ? blk_b : blk_a);
   endfunction : mrs_ok

   // burst mask of one mask cycle, low byte from the rising edge
   function automatic logic [15:0] burst_mask(input logic [10:0] rr, input logic [10:0] ff);
      return {ff[7:0], rr[7:0]};
   endfunction : burst_mask

   task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task give_verdict();
      if (num_errors == 0 && check_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : give_verdict

   // a trailing nop lets the decoder take the last cycle, then results settle
   task fin();
      u_ctrl.cyc(11'h300, 11'h300, 1'h0);
      #1;
   endtask : fin

   task mask_cyc(output logic [15:0] m);
      logic [10:0] rr;
      logic [10:0] ff;
      rr = 11'($urandom) | 11'h300;
      ff = 11'($urandom) | 11'h300;
      u_ctrl.cyc(rr, ff, 1'h0);
      m = burst_mask(rr, ff);
   endtask : mask_cyc

   task mrs_do(input logic [3:0] a, input logic [11:0] op);
      logic ok;
      u_ctrl.cyc({3'b010, a, op[3:0]}, {3'b010, op[11:4]}, 1'h0);
      ok = mrs_ok(a);
      if (a == sgcd_pkg::MRA_CTRL) begin
         blk_a = op[0];
         blk_b = op[1];
         sel = op[3:2];
      end
      fin();
      chk("mrs_valid", ok, mrs_valid);
      chk("mrs_vendor", ok && (a == 4'hd || a == 4'he), mrs_vendor);
      chk("mrs addr", a, mrs.addr);
      if (a != sgcd_pkg::MRA_CTRL) chk("mrs op", op, mrs.op);
      chk("block a", blk_a, blk_a_o);
      chk("block b", blk_b, blk_b_o);
      chk("training select", sel, sel_o);
   endtask : mrs_do

   task cmd_do(input int i);
      r = (11'($urandom) & ~mr_t[i]) | vr_t[i];
      f = (11'($urandom) & ~mf_t[i]) | vf_t[i];
      u_ctrl.cyc(r, f, 1'h0);
      if (i >= 9) mask_cyc(m0);
      if (i == 10) mask_cyc(m1);
      fin();
      chk("cmd_valid", i != 0, cmd_valid);
      if (i != 0) chk("kind", kd_t[i], cmd.kind);
      chk("array_access", (i inside {2, 3, 9, 10}) && f[3], array_access);
      if (i inside {1, 2, 3, 4, 9, 10} || (i inside {7, 8} && !f[4])) begin
         chk("bank", r[7:4], cmd.bank);
      end
      if (i == 1) chk("row", {f[9:0], r[3:0]}, cmd.row);
      if (i == 4) chk("ldff data", {f[5:0], r[3:0]}, cmd.ldff_data);
      if (i inside {2, 3, 5, 6, 9, 10}) chk("chan_en", f[3], cmd.chan_en);
      if (i inside {2, 3, 7, 8, 9, 10}) chk("auto_pre", f[4], cmd.auto_pre);
      if (i inside {2, 3, 9, 10}) begin
         chk("col", {f[2:0], r[3:0]}, cmd.col);
         chk("mask kind", i == 9 ? sgcd_pkg::M_DOUBLE : i == 10 ? sgcd_pkg::M_SINGLE :
            sgcd_pkg::M_NONE, cmd.mask_kind);
      end
      if (i >= 9) chk("mask0", m0, cmd.mask0);
      if (i == 10) chk("mask1", m1, cmd.mask1);
   endtask : cmd_do

   initial begin
      clk_sys = 1'h0;
      forever #5 clk_sys = ~clk_sys;
   end

   // watchdog: a hang ends the run as a failure
   initial begin
      #200000;
      num_errors++;
      give_verdict();
   end

   initial begin
      rstn = 1'h0;
      chan_is_b = 1'h0;
      ca_inv_en = 1'h0;
      {blk_a, blk_b, sel} = 4'h0;
      num_errors = 0;
      check_count = 0;
      void'($urandom(95));
      repeat (8) @(posedge clk_sys);
      rstn <= 1'h1;
      repeat (2) u_ctrl.cyc(11'h300, 11'h300, 1'h0);
      // corner: block a with junk on the falling edge, then a refused write
      mrs_do(4'hf, 12'hff1);
      mrs_do(4'h3, 12'($urandom));
      // same write stream served as channel a or b, block bits set at random
      for (k = 0; k < 48; k++) begin
         @(posedge clk_sys);
         chan_is_b <= 1'($urandom);
         mrs_do(k % 3 == 0 ? 4'hf : 4'($urandom_range(14)), 12'($urandom));
      end
      mrs_do(4'hf, 12'h000);
      // every command once, then random ones; inversion active in the second half
      for (k = 0; k < 120; k++) begin
         @(posedge clk_sys);
         ca_inv_en <= k >= 60;
         cmd_do(k < 11 ? k : $urandom_range(10));
      end
      u_ctrl.cyc(11'($urandom) | 11'h300, 11'($urandom), 1'h1);
      fin();
      chk("pde valid", 1'h1, cmd_valid);
      chk("pde kind", sgcd_pkg::K_PDE, cmd.kind);
      give_verdict();
   end
endmodule : sgram_command_decoder_test
